// ### iea_defines.svh
// Offsets, field positions, reset values and cycle counts of the execute unit.
// Assumes a 32-bit Wishbone data path with byte addresses on eight address bits.
`ifndef IEA_DEFINES_SVH
`define IEA_DEFINES_SVH
// Register byte offsets
`define IEA_REG_CMD     8'h00
`define IEA_REG_CTRL    8'h04
`define IEA_REG_ACC     8'h08
`define IEA_REG_FLAGS   8'h0C
`define IEA_REG_PC      8'h10
`define IEA_REG_TBL     8'h14
`define IEA_REG_WDOG    8'h18
`define IEA_REG_STACK   8'h1C
`define IEA_DMEM_TAG    2'h1
// Command field positions
`define IEA_CMD_M_LSB   8
`define IEA_CMD_BIT_LSB 12
`define IEA_CMD_ARG_LSB 16
`define IEA_TBL_PG_LSB  16
// Flag bit positions
`define IEA_FLG_C       0
`define IEA_FLG_AUX     1
`define IEA_FLG_Z       2
`define IEA_FLG_OV      3
`define IEA_FLG_SGN     4
`define IEA_FLG_TO      5
`define IEA_FLG_PD      6
// Reset values
`define IEA_RST_BYTE    8'h00
`define IEA_RST_FLAG    1'b0
// Cycle counts
`define IEA_CYC_SHORT   2'h1
`define IEA_CYC_BASE    2'h2
`define IEA_CYC_SKIP    2'h3
`define IEA_CYC_TABLE   2'h3
`define IEA_CYC_PC_LOW  2'h3
`define IEA_CYC_CALL    2'h2
// Data address that mirrors the program counter low byte
`define IEA_PC_LOW_ADDR 4'hF
// Decimal adjust limits
`define IEA_BCD_MAX     4'h9
`define IEA_BCD_FIX     4'h6
// Watchdog prescaler terminal count
`define IEA_WDOG_PRESC  8'hFF
`endif

// ### iea_pkg.sv
// Types shared by the execute unit: operation codes and sequencer states.
// Assumes nothing beyond a SystemVerilog compiler.
package iea_pkg;
  // Operation codes, numbered in declaration order from zero
  typedef enum logic [5:0] {
    op_nop, op_add, add_to_mem_op, op_add_carry, add_carry_to_mem_op, op_add_imm,
    op_and, and_to_mem_op, op_and_imm, op_call, op_clear, op_clear_bit,
    op_clear_wdog, complement_op, complement_to_acc_op, decimal_adjust_op,
    decrement_op, decrement_to_acc_op, op_halt, op_skip_zero, ext_skip_zero_move_op,
    op_skip_nonzero, op_skip_bit_zero, op_skip_bit_one, ext_incr_skip_zero_op,
    ext_decr_skip_zero_op, op_incr_skip_acc, op_decr_skip_acc,
    ext_table_read_page_op, ext_table_read_last_op, ext_incr_table_read_op,
    op_incr_table_last, op_set, op_swap, ext_nibble_swap_acc_op
  } iea_op_t;
  // Sequencer states
  typedef enum logic [1:0] {st_idle, st_exec, st_halt} iea_state_t;
endpackage

// ### iea_core.sv
// Execute unit of an 8-bit core: ALU, skips, table reads, call, halt, watchdog.
// Assumes a classic Wishbone master and a program memory with registered output.
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/1ps
`include "iea_defines.svh"

module iea_core
  import iea_pkg::*;
#(
  parameter int PC_W  = 12,  // Program counter width
  parameter int DM_AW = 4,   // Data address width
  parameter int STK_D = 8,   // Return stack depth
  parameter int WD_W  = 8    // Watchdog counter width
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Wishbone slave
  input  wire logic             wb_cyc,
  input  wire logic             wb_stb,
  input  wire logic             wb_we,
  input  wire logic [7:0]       wb_adr,
  input  wire logic [31:0]      wb_wdata,
  input  wire logic [3:0]       wb_sel,
  output logic      [31:0]      wb_rdata,
  output logic                  wb_ack,
  // Program memory read port
  output logic      [PC_W-1:0]  pm_addr,
  input  wire logic [15:0]      pm_rdata,
  // Power control
  input  wire logic             wake_req,
  output logic                  clk_run
);

  localparam int PG_W  = PC_W - 8;          // Table page width
  localparam int DM_N  = (1 << DM_AW) - 1;  // Array bytes; top address is PC low
  localparam int SP_W  = $clog2(STK_D);

  // Architectural state
  logic [7:0]       acc_reg;               // Accumulator
  logic             carry_flag_reg;        // Carry
  logic             aux_carry_flag_reg;    // Carry out of bit 3
  logic             zero_flag_reg;         // Zero
  logic             overflow_flag_reg;     // Signed overflow
  logic             signed_compare_flag_reg; // Overflow xor sign
  logic             timeout_flag_reg;      // Watchdog expired
  logic             powerdown_flag_reg;    // Halt entered
  logic [PC_W-1:0]  pc_reg;                // Program counter
  logic [7:0]       table_pointer_reg;     // Table pointer
  logic [PG_W-1:0]  table_page_reg;        // Selected table page
  logic [7:0]       table_high_byte_reg;   // High byte of last table word
  logic [7:0]       dmem [0:DM_N-1];       // Data memory
  logic [PC_W-1:0]  stack_mem [0:STK_D-1]; // Return stack
  logic [SP_W-1:0]  sp_reg;                // Stack pointer
  logic [WD_W-1:0]  watchdog_counter_reg;  // Watchdog count
  logic [7:0]       presc_reg;             // Watchdog prescaler

  // Sequencer and latched command
  iea_state_t       state_reg;
  logic [1:0]       cnt_reg;               // Cycle within instruction
  iea_op_t          op_reg;
  logic [DM_AW-1:0] m_reg;                 // Operand address
  logic [2:0]       bit_reg;               // Bit select
  logic [15:0]      arg_reg;               // Immediate or call target
  logic             skip_reg;              // Last instruction skipped
  logic [PC_W-1:0]  pm_addr_reg;

  // Bus
  logic             ack_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;

  // Decode results
  logic [7:0]       res;
  logic             wr_acc, wr_mem, upd_z, upd_arith, upd_c, skip;
  logic             do_call, do_tbl, do_clrwd, do_halt;
  logic [1:0]       need;

  // Bus decode; writes land on the edge that raises ack
  logic             bus_req, bus_wr, idle, wr_ok, issue, wake;
  logic             hit_dm;
  logic [DM_AW-1:0] dm_idx;
  iea_op_t          iss_op;
  logic             iss_incr, iss_last;
  logic [7:0]       tp_use;

  assign bus_req  = wb_cyc & wb_stb & ~ack_reg;
  assign bus_wr   = bus_req & wb_we;
  assign idle     = (state_reg == st_idle);
  // Writes outside idle are acked but dropped, except the CTRL wake bit, so operands stay stable
  assign wr_ok    = bus_wr & wb_sel[0] & idle;
  assign issue    = wr_ok & (wb_adr == `IEA_REG_CMD);
  assign hit_dm   = (wb_adr[7:6] == `IEA_DMEM_TAG) & (wb_adr[1:0] == 2'h0);
  assign dm_idx   = wb_adr[DM_AW+1:2];
  assign wake     = wake_req | (bus_wr & wb_sel[0] & wb_wdata[0] & (wb_adr == `IEA_REG_CTRL));
  assign iss_op   = iea_op_t'(wb_wdata[5:0]);
  assign iss_incr = iss_op inside {ext_incr_table_read_op, op_incr_table_last};
  assign iss_last = iss_op inside {ext_table_read_last_op, op_incr_table_last};
  assign tp_use   = iss_incr ? table_pointer_reg + 8'h01 : table_pointer_reg;

  // Operand and arithmetic terms
  logic [7:0] mem_b, opnd;
  logic       cin, zero_b, lo_adj, hi_adj, to_pc_low, done;
  logic [8:0] sum9;
  logic [4:0] lo5;
  logic [7:0] bcd_res;

  assign mem_b   = (m_reg == `IEA_PC_LOW_ADDR) ? pc_reg[7:0] : dmem[m_reg];
  assign opnd    = (op_reg inside {op_add_imm, op_and_imm}) ? arg_reg[7:0] : mem_b;
  assign cin     = (op_reg inside {op_add_carry, add_carry_to_mem_op}) & carry_flag_reg;
  assign sum9    = {1'b0, acc_reg} + {1'b0, opnd} + {8'h00, cin};
  assign lo5     = {1'b0, acc_reg[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  assign zero_b  = (mem_b == 8'h00);
  assign lo_adj  = (acc_reg[3:0] > `IEA_BCD_MAX) | aux_carry_flag_reg;
  assign hi_adj  = (acc_reg[7:4] > `IEA_BCD_MAX) | carry_flag_reg;
  assign bcd_res = acc_reg + {(hi_adj ? `IEA_BCD_FIX : 4'h0), (lo_adj ? `IEA_BCD_FIX : 4'h0)};

  // Operation decode from the latched command
  always_comb begin
    res       = 8'h00;
    wr_acc    = 1'b0;
    wr_mem    = 1'b0;
    upd_z     = 1'b0;
    upd_arith = 1'b0;
    upd_c     = 1'b0;
    skip      = 1'b0;
    do_call   = 1'b0;
    do_tbl    = 1'b0;
    do_clrwd  = 1'b0;
    do_halt   = 1'b0;
    need      = `IEA_CYC_BASE;
    case (op_reg)
      op_add, op_add_carry, op_add_imm: begin
        res       = sum9[7:0];
        wr_acc    = 1'b1;
        upd_arith = 1'b1;
        if (op_reg == op_add_imm) begin
          need = `IEA_CYC_SHORT;                   // Immediate form is single cycle
        end
      end
      add_to_mem_op, add_carry_to_mem_op: begin
        res       = sum9[7:0];
        wr_mem    = 1'b1;
        upd_arith = 1'b1;
      end
      op_and, op_and_imm: begin
        res    = acc_reg & opnd;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
        if (op_reg == op_and_imm) begin
          need = `IEA_CYC_SHORT;
        end
      end
      and_to_mem_op: begin
        res    = acc_reg & mem_b;
        wr_mem = 1'b1;
        upd_z  = 1'b1;
      end
      op_call: begin
        do_call = 1'b1;
        need    = `IEA_CYC_CALL;
      end
      op_clear: begin
        res    = 8'h00;
        wr_mem = 1'b1;
      end
      op_clear_bit: begin
        res    = mem_b & ~(8'h01 << bit_reg);
        wr_mem = 1'b1;
      end
      op_set: begin
        res    = 8'hFF;
        wr_mem = 1'b1;
      end
      op_swap, ext_nibble_swap_acc_op: begin
        res    = {mem_b[3:0], mem_b[7:4]};
        wr_mem = (op_reg == op_swap);
        wr_acc = (op_reg == ext_nibble_swap_acc_op);
      end
      op_clear_wdog: begin
        do_clrwd = 1'b1;
        need     = `IEA_CYC_SHORT;
      end
      complement_op, complement_to_acc_op: begin
        res    = ~mem_b;
        wr_mem = (op_reg == complement_op);
        wr_acc = (op_reg == complement_to_acc_op);
        upd_z  = 1'b1;
      end
      decimal_adjust_op: begin
        res    = bcd_res;
        wr_mem = 1'b1;
        upd_c  = 1'b1;
      end
      decrement_op, decrement_to_acc_op: begin
        res    = mem_b - 8'h01;
        wr_mem = (op_reg == decrement_op);
        wr_acc = (op_reg == decrement_to_acc_op);
        upd_z  = 1'b1;
      end
      op_halt: begin
        do_halt = 1'b1;
        need    = `IEA_CYC_SHORT;
      end
      op_skip_zero: begin
        skip = zero_b;
      end
      ext_skip_zero_move_op: begin
        res    = mem_b;
        wr_acc = 1'b1;
        skip   = zero_b;
      end
      op_skip_nonzero: begin
        skip = ~zero_b;
      end
      op_skip_bit_zero: begin
        skip = ~mem_b[bit_reg];
      end
      op_skip_bit_one: begin
        skip = mem_b[bit_reg];
      end
      ext_incr_skip_zero_op, op_incr_skip_acc: begin
        res    = mem_b + 8'h01;
        wr_mem = (op_reg == ext_incr_skip_zero_op);
        wr_acc = (op_reg == op_incr_skip_acc);
        skip   = (res == 8'h00);
      end
      ext_decr_skip_zero_op, op_decr_skip_acc: begin
        res    = mem_b - 8'h01;
        wr_mem = (op_reg == ext_decr_skip_zero_op);
        wr_acc = (op_reg == op_decr_skip_acc);
        skip   = (res == 8'h00);
      end
      ext_table_read_page_op, ext_table_read_last_op, ext_incr_table_read_op, op_incr_table_last: begin
        res    = pm_rdata[7:0];
        wr_mem = 1'b1;
        do_tbl = 1'b1;
        need   = `IEA_CYC_TABLE;
      end
      default: begin
        need = `IEA_CYC_SHORT;                      // No operation
      end
    endcase
    if (skip) begin
      need = `IEA_CYC_SKIP;
    end
    if (wr_mem && (m_reg == `IEA_PC_LOW_ADDR)) begin
      need = `IEA_CYC_PC_LOW;
    end
  end

  assign to_pc_low = wr_mem & (m_reg == `IEA_PC_LOW_ADDR);
  // Commit on the last cycle of the instruction
  assign done      = (state_reg == st_exec) && (cnt_reg == need);

  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= st_idle;
      cnt_reg   <= 2'h0;
    end else begin
      case (state_reg)
        st_idle: begin
          if (issue) begin
            state_reg <= st_exec;
            cnt_reg   <= 2'h1;
          end
        end
        st_exec: begin
          if (done) begin
            state_reg <= do_halt ? st_halt : st_idle;
            cnt_reg   <= 2'h0;
          end else begin
            cnt_reg <= cnt_reg + 2'h1;
          end
        end
        st_halt: begin
          if (wake) begin
            state_reg <= st_idle;
          end
        end
        default: begin
          state_reg <= st_idle;
        end
      endcase
    end
  end

  // Command latch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_reg  <= op_nop;
      m_reg   <= '0;
      bit_reg <= 3'h0;
      arg_reg <= 16'h0000;
    end else if (issue) begin
      op_reg  <= iss_op;
      m_reg   <= wb_wdata[`IEA_CMD_M_LSB +: DM_AW];
      bit_reg <= wb_wdata[`IEA_CMD_BIT_LSB +: 3];
      arg_reg <= wb_wdata[`IEA_CMD_ARG_LSB +: 16];
    end
  end

  // Accumulator
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_reg <= `IEA_RST_BYTE;
    end else if (wr_ok && (wb_adr == `IEA_REG_ACC)) begin
      acc_reg <= wb_wdata[7:0];
    end else if (done && wr_acc) begin
      acc_reg <= res;
    end
  end

  // Arithmetic flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      carry_flag_reg          <= `IEA_RST_FLAG;
      aux_carry_flag_reg      <= `IEA_RST_FLAG;
      zero_flag_reg           <= `IEA_RST_FLAG;
      overflow_flag_reg       <= `IEA_RST_FLAG;
      signed_compare_flag_reg <= `IEA_RST_FLAG;
    end else if (wr_ok && (wb_adr == `IEA_REG_FLAGS)) begin
      carry_flag_reg          <= wb_wdata[`IEA_FLG_C];
      aux_carry_flag_reg      <= wb_wdata[`IEA_FLG_AUX];
      zero_flag_reg           <= wb_wdata[`IEA_FLG_Z];
      overflow_flag_reg       <= wb_wdata[`IEA_FLG_OV];
      signed_compare_flag_reg <= wb_wdata[`IEA_FLG_SGN];
    end else if (done) begin
      if (upd_arith) begin
        carry_flag_reg          <= sum9[8];
        aux_carry_flag_reg      <= lo5[4];
        overflow_flag_reg       <= (acc_reg[7] == opnd[7]) & (sum9[7] != acc_reg[7]);
        signed_compare_flag_reg <= ((acc_reg[7] == opnd[7]) & (sum9[7] != acc_reg[7])) ^ sum9[7];
      end
      if (upd_arith || upd_z) begin
        zero_flag_reg <= (res == 8'h00);
      end
      if (upd_c) begin
        carry_flag_reg <= hi_adj;
      end
    end
  end

  // Watchdog; a timeout in the clearing cycle still sets its flag
  logic wd_tick, wd_expire, wd_clear;
  assign wd_tick   = (presc_reg == `IEA_WDOG_PRESC) && (state_reg != st_halt);
  assign wd_expire = wd_tick && (watchdog_counter_reg == {WD_W{1'b1}});
  assign wd_clear  = done && (do_clrwd || do_halt);

  always_ff @(posedge sys_clk) begin
    if (rst || wd_clear) begin
      presc_reg            <= 8'h00;
      watchdog_counter_reg <= '0;
    end else if (state_reg != st_halt) begin
      presc_reg <= wd_tick ? 8'h00 : presc_reg + 8'h01;
      if (wd_tick) begin
        watchdog_counter_reg <= watchdog_counter_reg + 1'b1;
      end
    end
  end

  // Timeout and powerdown flags
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timeout_flag_reg   <= `IEA_RST_FLAG;
      powerdown_flag_reg <= `IEA_RST_FLAG;
    end else begin
      if (done && do_clrwd) begin
        timeout_flag_reg   <= 1'b0;
        powerdown_flag_reg <= 1'b0;
      end
      if (done && do_halt) begin
        timeout_flag_reg   <= 1'b0;
        powerdown_flag_reg <= 1'b1;
      end
      if (wd_expire) begin
        timeout_flag_reg <= 1'b1;
      end
    end
  end

  // System clock enable; data and registers hold while it is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_run <= 1'b1;
    end else if (done && do_halt) begin
      clk_run <= 1'b0;
    end else if ((state_reg == st_halt) && wake) begin
      clk_run <= 1'b1;
    end
  end

  // Data memory; the top address lands in the program counter instead
  always_ff @(posedge sys_clk) begin
    if (wr_ok && hit_dm && (dm_idx != `IEA_PC_LOW_ADDR)) begin
      dmem[dm_idx] <= wb_wdata[7:0];
    end else if (done && wr_mem && !to_pc_low) begin
      dmem[m_reg] <= res;
    end
  end

  // Program counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_reg <= '0;
    end else if (wr_ok && (wb_adr == `IEA_REG_PC)) begin
      pc_reg <= wb_wdata[PC_W-1:0];
    end else if (wr_ok && hit_dm && (dm_idx == `IEA_PC_LOW_ADDR)) begin
      pc_reg[7:0] <= wb_wdata[7:0];
    end else if (done) begin
      if (do_call) begin
        pc_reg <= arg_reg[PC_W-1:0];
      end else if (to_pc_low) begin
        pc_reg <= {pc_reg[PC_W-1:8], res};
      end else begin
        pc_reg <= pc_reg + PC_W'(1) + PC_W'(skip);
      end
    end
  end

  // Return stack; wraps when full
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sp_reg <= '0;
    end else if (done && do_call) begin
      stack_mem[sp_reg] <= pc_reg + PC_W'(1);
      sp_reg            <= sp_reg + 1'b1;
    end
  end

  // Skip status
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      skip_reg <= 1'b0;
    end else if (done) begin
      skip_reg <= skip;
    end
  end

  // Table pointer, page, high byte and program memory address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      table_pointer_reg   <= `IEA_RST_BYTE;
      table_page_reg      <= '0;
      table_high_byte_reg <= `IEA_RST_BYTE;
      pm_addr_reg         <= '0;
    end else begin
      if (wr_ok && (wb_adr == `IEA_REG_TBL)) begin
        table_pointer_reg <= wb_wdata[7:0];
        if (wb_sel[2]) begin
          table_page_reg <= wb_wdata[`IEA_TBL_PG_LSB +: PG_W];
        end
      end
      if (issue) begin
        table_pointer_reg <= tp_use;
        pm_addr_reg       <= {(iss_last ? {PG_W{1'b1}} : table_page_reg), tp_use};
      end
      if (done && do_tbl) begin
        table_high_byte_reg <= pm_rdata[15:8];
      end
    end
  end

  assign pm_addr = pm_addr_reg;

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_dm) begin
      rdata_next[7:0] = (dm_idx == `IEA_PC_LOW_ADDR) ? pc_reg[7:0] : dmem[dm_idx];
    end else begin
      case (wb_adr)
        `IEA_REG_CMD:   rdata_next = {arg_reg, 1'b0, bit_reg, 4'(m_reg), 2'h0, op_reg};
        `IEA_REG_CTRL:  rdata_next = {29'h0, skip_reg, (state_reg == st_halt), (state_reg == st_exec)};
        `IEA_REG_ACC:   rdata_next[7:0] = acc_reg;
        `IEA_REG_FLAGS: rdata_next[6:0] = {powerdown_flag_reg, timeout_flag_reg, signed_compare_flag_reg,
                                           overflow_flag_reg, zero_flag_reg, aux_carry_flag_reg, carry_flag_reg};
        `IEA_REG_PC:    rdata_next[PC_W-1:0] = pc_reg;
        `IEA_REG_TBL:   rdata_next = {8'h00, 8'(table_page_reg), table_high_byte_reg, table_pointer_reg};
        `IEA_REG_WDOG:  rdata_next[WD_W-1:0] = watchdog_counter_reg;
        `IEA_REG_STACK: rdata_next = {8'(sp_reg), 8'h00, 16'(stack_mem[sp_reg - 1'b1])};
        default:        rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      if (bus_req) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign wb_ack   = ack_reg;
  assign wb_rdata = rdata_reg;

endmodule

// ### iea_pmem.sv
// Program memory model: each word is a fixed pattern of its address.
// Assumes the execute unit samples the word three edges after the address.
`timescale 1ns/1ps
module iea_pmem (
  // Clock
  input  wire logic        sys_clk,
  // Read port
  input  wire logic [11:0] pm_addr,
  output logic      [15:0] pm_rdata
);
  // Registered read; high byte shows the page, low byte the offset
  always_ff @(posedge sys_clk) begin
    pm_rdata <= {4'h5, pm_addr};
  end
endmodule

// ### iea_chk_props.sv
// Checker for the execute unit's bus answer, fetch address and clock enable.
// Bound to iea_core; sees only its ports.
`timescale 1ns/1ps
module iea_chk #(
  parameter int PC_W = 12  // Program counter width
) (
  // Clock and reset
  input wire logic            sys_clk,
  input wire logic            rst,
  // Register bus
  input wire logic            wb_cyc,
  input wire logic            wb_stb,
  input wire logic            wb_we,
  input wire logic [7:0]      wb_adr,
  input wire logic [31:0]     wb_wdata,
  input wire logic [3:0]      wb_sel,
  input wire logic [31:0]     wb_rdata,
  input wire logic            wb_ack,
  // Fetch and power
  input wire logic [PC_W-1:0] pm_addr,
  input wire logic            wake_req,
  input wire logic            clk_run
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Request taken, command issued, halt issued, wake asked, unmapped read
  logic tk, cmd, hlt, wk, urd;
  assign tk  = wb_cyc && wb_stb && !wb_ack;
  // Writes without the low byte lane are dropped by the unit, so they issue nothing
  assign cmd = tk && wb_we && wb_sel[0] && wb_adr == 8'h00;
  assign hlt = cmd && wb_wdata[5:0] == 6'h12;
  assign wk  = wake_req || (tk && wb_we && wb_sel[0] && wb_adr == 8'h04 && wb_wdata[0]);
  assign urd = !wb_we && wb_adr[7:5] == 3'h1;
  // Halt accepted while running
  sequence s_halt;
    hlt && clk_run;
  endsequence
  a_ack_pulse: assert property (wb_ack |=> !wb_ack) else $error("ack held too long");
  a_ack_answer: assert property (tk |=> wb_ack) else $error("request not answered");
  a_ack_cause: assert property (wb_ack |-> $past(tk)) else $error("ack without request");
  a_halt_stops: assert property (s_halt |-> ##[1:2] !clk_run) else $error("halt left clock on");
  a_stop_cause: assert property ($fell(clk_run) |-> $past(hlt) || $past(hlt, 2)) else $error("clock stopped");
  a_wake_starts: assert property (!clk_run && wk |-> ##[1:2] clk_run) else $error("wake ignored");
  a_fetch_issue: assert property ($changed(pm_addr) |-> $past(cmd)) else $error("fetch address moved");
  a_unmapped_zero: assert property (wb_ack && $past(urd) |-> wb_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind iea_core iea_chk #(.PC_W(PC_W)) iea_chk_inst (.sys_clk(sys_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_we(wb_we), .wb_adr(wb_adr), .wb_wdata(wb_wdata), .wb_sel(wb_sel), .wb_rdata(wb_rdata), .wb_ack(wb_ack),
  .pm_addr(pm_addr),
  .wake_req(wake_req), .clk_run(clk_run));

// ### testbench.sv
// Self-checking bench: runs each operation except op_nop through the register bus.
// Assumes iea_core, its bound checker and the program memory model.
`timescale 1ns/1ps
module testbench;
  logic        sys_clk = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, wake_req = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'hF;
  logic [31:0] wb_wdata = 32'h0, wb_rdata, rd;
  logic [11:0] pm_addr;
  logic [15:0] pm_rdata;
  logic        clk_run;
  int          fail_count = 0, check_count = 0, cycles = 0, np = 0;
  always #50 sys_clk = ~sys_clk;
  // Two-bit watchdog so a timeout shows up well inside the run
  iea_core #(.WD_W(2)) iea_core_inst (.sys_clk(sys_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_wdata(wb_wdata), .wb_sel(wb_sel), .wb_rdata(wb_rdata), .wb_ack(wb_ack),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .wake_req(wake_req), .clk_run(clk_run));
  iea_pmem iea_pmem_inst (.sys_clk(sys_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata));
  task automatic print_verdict;
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One classic cycle; holds everything until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_adr   <= a;
    wb_wdata <= d;
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    rd = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  // Issue a command, wait for busy to fall, then check one register; np counts busy polls
  task automatic t(input logic [5:0] op, input logic [3:0] m, input logic [2:0] b, input logic [15:0] x,
                   input logic [7:0] a, input logic [31:0] e);
    wb(1'b1, 8'h00, {x, 1'b0, b, m, 2'h0, op});
    np = 0;
    do begin
      wb(1'b0, 8'h04, 32'h0);
      np++;
    end while (rd[0] !== 1'b0);
    rc(a, e);
  endtask
  // Hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    wb(1'b1, 8'h08, 32'h59);
    wb(1'b1, 8'h44, 32'h38);
    wb(1'b1, 8'h54, 32'h01);
    wb(1'b1, 8'h58, 32'hFF);
    t(6'h01, 4'h1, '0, '0, 8'h0C, 32'h0A);
    t(6'h0F, 4'h2, '0, '0, 8'h48, 32'h97);
    rc(8'h0C, 32'h0A);
    t(6'h05, '0, '0, 16'h55, 8'h0C, 32'h10);
    t(6'h0F, 4'h3, '0, '0, 8'h4C, 32'h46);
    rc(8'h0C, 32'h11);
    t(6'h03, 4'h1, '0, '0, 8'h0C, 32'h01);
    t(6'h07, 4'h1, '0, '0, 8'h44, 32'h18);
    t(6'h08, '0, '0, 16'hE0, 8'h0C, 32'h05);
    t(6'h0D, 4'h2, '0, '0, 8'h48, 32'h68);
    t(6'h0E, 4'h3, '0, '0, 8'h08, 32'hB9);
    t(6'h0A, 4'h3, '0, '0, 8'h4C, 32'h00);
    t(6'h0B, 4'h2, 3'h3, '0, 8'h48, 32'h60);
    t(6'h10, 4'h5, '0, '0, 8'h0C, 32'h05);
    t(6'h11, 4'h5, '0, '0, 8'h08, 32'hFF);
    t(6'h13, 4'h5, '0, '0, 8'h04, 32'h04);
    chk("polls", 32'h2, np);
    t(6'h14, 4'h1, '0, '0, 8'h08, 32'h18);
    chk("polls", 32'h1, np);
    t(6'h18, 4'h6, '0, '0, 8'h04, 32'h04);
    t(6'h1B, 4'h1, '0, '0, 8'h08, 32'h17);
    t(6'h22, 4'h2, '0, '0, 8'h08, 32'h06);
    chk("polls", 32'h1, np);
    wb(1'b1, 8'h14, 32'h20010);
    t(6'h1C, 4'h7, '0, '0, 8'h5C, 32'h10);
    chk("polls", 32'h2, np);
    t(6'h1F, 4'h8, '0, '0, 8'h14, 32'h25F11);
    wb(1'b1, 8'h10, 32'hA0);
    t(6'h09, '0, '0, 16'h123, 8'h1C, 32'h10000A1);
    wb(1'b1, 8'h10, 32'h2AB);
    t(6'h0A, 4'hF, '0, '0, 8'h10, 32'h200);
    chk("polls", 32'h2, np);
    t(6'h12, '0, '0, '0, 8'h0C, 32'h41);
    rc(8'h18, 32'h0);
    chk("clk_run", 32'h0, {31'h0, clk_run});
    wake_req <= 1'b1;
    @(posedge sys_clk);
    wake_req <= 1'b0;
    @(posedge sys_clk);
    chk("clk_run", 32'h1, {31'h0, clk_run});
    // Let the watchdog run out so the clear has a timeout flag to drop
    repeat (1100) @(posedge sys_clk);
    rc(8'h0C, 32'h61);
    t(6'h0C, '0, '0, '0, 8'h0C, 32'h01);
    rc(8'h18, 32'h0);
    // Memory-destination, accumulator AND, skip and table forms not reached above
    t(6'h04, 4'h2, '0, '0, 8'h48, 32'h67);
    t(6'h02, 4'h1, '0, '0, 8'h44, 32'h1E);
    t(6'h06, 4'h7, '0, '0, 8'h0C, 32'h04);
    t(6'h15, 4'h8, '0, '0, 8'h04, 32'h04);
    t(6'h16, 4'h7, 3'h4, '0, 8'h04, 32'h00);
    t(6'h17, 4'h7, 3'h4, '0, 8'h04, 32'h04);
    t(6'h19, 4'h3, '0, '0, 8'h4C, 32'hFF);
    t(6'h1A, 4'h3, '0, '0, 8'h04, 32'h04);
    rc(8'h4C, 32'hFF);
    t(6'h20, 4'h5, '0, '0, 8'h54, 32'hFF);
    t(6'h21, 4'h2, '0, '0, 8'h48, 32'h76);
    t(6'h1E, 4'h9, '0, '0, 8'h14, 32'h25212);
    t(6'h1D, 4'hA, '0, '0, 8'h14, 32'h25F12);
    rc(8'h30, 32'h0);
    print_verdict();
  end
endmodule
